// >>> logic/dbcc_pkg.sv
// Package for the dual battery charge control block
`default_nettype none
package dbcc_pkg;
	localparam int unsigned CLK_MHZ          = 100;
	localparam int unsigned QUERY_MS         = 250;
	localparam int unsigned TIMEOUT_S        = 140;
	localparam int unsigned QUERY_CYC_DFLT   = QUERY_MS * 1000 * CLK_MHZ;
	localparam int unsigned TIMEOUT_QUERIES  = TIMEOUT_S * 1000 / QUERY_MS;
	// APB register byte addresses
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IPROG  = 8'h08;
	// Control register field positions
	localparam int unsigned CTL_INHIBIT = 0;
	localparam int unsigned CTL_CALIB   = 1;
	localparam int unsigned CTL_PNG     = 2;
	localparam int unsigned CTL_POR     = 3;
	localparam logic [3:0] CTRL_RESET  = 4'h0;
	// Upper four alarm bits that stop charging
	localparam int unsigned ALARM_LO    = 12;
	localparam int unsigned LIMIT_SHIFT = 5;
	typedef enum logic [2:0]
	{
		TH_UNDER = 3'h0,
		TH_COLD  = 3'h1,
		TH_IDEAL = 3'h2,
		TH_HOT   = 3'h3,
		TH_OVER  = 3'h4
	} dbcc_therm_e;
	typedef enum logic [2:0]
	{
		CMD_ALARM  = 3'h0,
		CMD_CHGV   = 3'h1,
		CMD_VOLT   = 3'h2,
		CMD_CHGI   = 3'h3,
		CMD_CURR   = 3'h4
	} dbcc_cmd_e;
	// One finished transfer from the SMBus engine, a master read or a received write (is_write)
	typedef struct packed
	{
		logic        valid;
		logic        bat;
		logic        ack;
		logic        is_write;
		dbcc_cmd_e   cmd;
		logic [15:0] data;
	} dbcc_rsp_s;
	// Poll request to the SMBus engine
	typedef struct packed
	{
		logic      valid;
		logic      bat;
		dbcc_cmd_e cmd;
	} dbcc_req_s;
endpackage : dbcc_pkg
`default_nettype wire

// >>> logic/dbcc_top.sv
// Dual battery charge control: wake-up, controlled charging and current loop
//
// The implementer's own choices: the placing of the registers and register access over APB.
`default_nettype none
module dbcc_top
	import dbcc_pkg::*;
#(
	parameter int unsigned       QUERY_CYC = QUERY_CYC_DFLT,
	parameter int unsigned       TMO_QRY   = TIMEOUT_QUERIES,
	parameter logic [15:0]       I_LIMIT   = 16'h0FA0,
	parameter logic [15:0]       V_LIMIT   = 16'h3A98,
	parameter logic [15:0]       I_WAKE    = 16'h0050
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic [2:0]  therm1,
	input  wire logic [2:0]  therm2,
	input  wire logic        mains_present,
	input  wire logic        mode_pin,
	input  wire logic        smbus_supply,
	input  wire logic        mains_sense_divided,
	input  wire logic [3:0]  smb_lines,
	output dbcc_req_s        poll_req,
	input  wire dbcc_rsp_s   poll_rsp,
	output logic [15:0]      prog_current,
	output logic [15:0]      prog_voltage,
	output logic             low_current_mode,
	output logic [1:0]       charge_en
);
	localparam int unsigned QW = $clog2(QUERY_CYC + 1);
	localparam int unsigned TW = $clog2(TMO_QRY + 2);
	initial
	begin
		if (QUERY_CYC < 16 || TMO_QRY < 1)
			$error("dbcc_top: period parameters too small");
	end

	// Pin synchronisers, three stages, change counted when last two agree
	logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
	logic [7:0] smb_s1_q, smb_s2_q, smb_s3_q;
	logic [3:0] smb_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_s1_q <= 4'h0;
			pin_s2_q <= 4'h0;
			pin_s3_q <= 4'h0;
			pin_q    <= 4'h0;
			smb_s1_q <= 8'hFF;
			smb_s2_q <= 8'hFF;
			smb_s3_q <= 8'hFF;
			smb_q    <= 4'hF;
		end
		else
		begin
			pin_s1_q <= {mains_present, mode_pin, smbus_supply, mains_sense_divided};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			if (pin_s2_q == pin_s3_q)
				pin_q <= pin_s3_q;
			smb_s1_q <= {4'hF, smb_lines};
			smb_s2_q <= smb_s1_q;
			smb_s3_q <= smb_s2_q;
			if (smb_s2_q[3:0] == smb_s3_q[3:0])
				smb_q <= smb_s3_q[3:0];
		end
	end
	logic ac_ok, hw_inhibit, estop;
	assign ac_ok      = pin_q[3];
	assign hw_inhibit = !pin_q[2] && pin_q[1];
	assign estop      = pin_q[0];

	// Host control bits over APB
	logic [3:0] ctrl_q;
	logic       apb_wr;
	assign apb_wr = psel && penable && pwrite;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_q <= CTRL_RESET;
		else if (apb_wr && paddr == ADDR_CTRL)
			ctrl_q <= pwdata[3:0];
		else
			ctrl_q[CTL_POR] <= 1'b0;
	end
	logic sw_inhibit, calib, pwr_ng, chg_por;
	assign sw_inhibit = ctrl_q[CTL_INHIBIT];
	assign calib      = ctrl_q[CTL_CALIB];
	assign pwr_ng     = ctrl_q[CTL_PNG];
	assign chg_por    = ctrl_q[CTL_POR];

	// stuck-low watchdog over all SMBus lines
	logic [QW-1:0] stuck_cnt_q;
	logic          stuck_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stuck_cnt_q <= '0;
			stuck_q     <= 1'b0;
		end
		else if (&smb_q)
		begin
			stuck_cnt_q <= '0;
			stuck_q     <= 1'b0;
		end
		else if (stuck_cnt_q < QW'(QUERY_CYC))
			stuck_cnt_q <= stuck_cnt_q + 1'b1;
		else
			stuck_q <= 1'b1;
	end

	logic [QW-1:0] qcnt_q;
	logic          tick;
	logic [3:0]    pidx_q;
	assign tick = (qcnt_q == QW'(QUERY_CYC - 1));
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			qcnt_q <= '0;
		else
			qcnt_q <= tick ? '0 : qcnt_q + 1'b1;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pidx_q   <= 4'hF;
			poll_req <= '0;
		end
		else if (tick)
		begin
			pidx_q   <= 4'h0;
			poll_req <= '{valid: 1'b1, bat: 1'b0, cmd: CMD_ALARM};
		end
		else if (poll_rsp.valid && !poll_rsp.is_write && pidx_q < 4'h9)
		begin
			pidx_q   <= pidx_q + 1'b1;
			poll_req <= '{valid: 1'b1, bat: pidx_q[0] ? 1'b0 : 1'b1,
				cmd: dbcc_cmd_e'(3'((pidx_q + 4'h1) >> 1))};
		end
		else if (poll_rsp.valid && !poll_rsp.is_write)
		begin
			pidx_q   <= 4'hF;
			poll_req <= '0;
		end
	end

	// Per-battery state
	logic [1:0]  alarm_q, wake_need_q, answered_q, seen_q;
	logic [1:0]  wake_q, gone, hot, coldish, reqz, cc_ok;
	logic [15:0] reqi_q [2], acti_q [2], reqv_q [2];
	logic [1:0]  gotv_q, goti_q;
	logic [TW-1:0] nack_q [2], wtime_q [2];
	logic        any_stop, charging_any;
	dbcc_therm_e th [2];
	assign th[0] = dbcc_therm_e'(therm1);
	assign th[1] = dbcc_therm_e'(therm2);

	generate
		for (genvar b = 0; b < 2; b++)
		begin : g_bat
			logic rsp_me;
			assign rsp_me  = poll_rsp.valid && !poll_rsp.is_write && poll_rsp.bat == b[0];
			assign gone[b] = (th[b] == TH_OVER);
			assign hot[b]  = (th[b] == TH_HOT);
			assign coldish[b] = (th[b] == TH_COLD) || (th[b] == TH_UNDER);
			assign reqz[b] = (reqv_q[b] == 16'h0000) || (reqi_q[b] == 16'h0000);
			assign cc_ok[b] = (coldish[b] || th[b] == TH_IDEAL) && !alarm_q[b] && !reqz[b]
				&& gotv_q[b] && goti_q[b] && nack_q[b] <= TW'(TMO_QRY);
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					alarm_q[b] <= 1'b0;
					reqi_q[b]  <= '0;
					acti_q[b]  <= '0;
					reqv_q[b]  <= '0;
					gotv_q[b]  <= 1'b0;
					goti_q[b]  <= 1'b0;
					answered_q[b] <= 1'b0;
					seen_q[b]  <= 1'b0;
					nack_q[b]  <= '0;
				end
				else if (gone[b] || chg_por)
				begin
					// removal or host reset clears cache except acti_q
					alarm_q[b] <= 1'b0;
					reqi_q[b]  <= '0;
					reqv_q[b]  <= '0;
					gotv_q[b]  <= 1'b0;
					goti_q[b]  <= 1'b0;
					answered_q[b] <= 1'b0;
					seen_q[b]  <= 1'b0;
					nack_q[b]  <= '0;
				end
				else if (rsp_me)
				begin
					seen_q[b] <= 1'b1;
					if (!poll_rsp.ack)
					begin
						if (poll_rsp.cmd == CMD_ALARM && nack_q[b] <= TW'(TMO_QRY))
							nack_q[b] <= nack_q[b] + 1'b1;
					end
					else
					begin
						nack_q[b] <= '0;
						unique case (poll_rsp.cmd)
							// upper four bits set the alarm; keeps it on silence
							CMD_ALARM: alarm_q[b] <= |poll_rsp.data[15:ALARM_LO];
							CMD_CHGV: reqv_q[b] <= poll_rsp.data;
							CMD_VOLT: gotv_q[b] <= 1'b1;
							CMD_CHGI: reqi_q[b] <= poll_rsp.data;
							CMD_CURR:
							begin
								acti_q[b] <= poll_rsp.data;
								goti_q[b] <= 1'b1;
							end
						endcase
						// any value read except the alarm word proves the battery talks
						if (poll_rsp.cmd != CMD_ALARM)
							answered_q[b] <= 1'b1;
					end
				end
			end
			assign wake_need_q[b] = seen_q[b] && !answered_q[b] && nack_q[b] != '0;
			// wake-up time for cold and under range
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					wtime_q[b] <= '0;
				else if (!wake_q[b] || gone[b] || chg_por)
					wtime_q[b] <= '0;
				else if (tick && wtime_q[b] <= TW'(TMO_QRY))
					wtime_q[b] <= wtime_q[b] + 1'b1;
			end
		end
	endgenerate

	// global stop conditions shared by both modes
	logic global_stop;
	assign global_stop = !ac_ok || sw_inhibit || hw_inhibit || pwr_ng || estop
		|| stuck_q || calib;
	logic [1:0] wake_end;
	assign wake_end[0] = gone[0] || answered_q[0] || alarm_q[0] || hot[0]
		|| (coldish[0] && wtime_q[0] > TW'(TMO_QRY));
	assign wake_end[1] = gone[1] || answered_q[1] || alarm_q[1] || hot[1]
		|| (coldish[1] && wtime_q[1] > TW'(TMO_QRY));
	// battery one wakes first, one at a time
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wake_q <= 2'b00;
		else if (global_stop)
			wake_q <= 2'b00;
		else if (wake_q[0])
			wake_q[0] <= !wake_end[0];
		else if (wake_q[1])
			wake_q[1] <= !wake_end[1];
		else if (wake_need_q[0] && !wake_end[0])
			wake_q <= 2'b01;
		else if (wake_need_q[1] && !wake_end[1])
			wake_q <= 2'b10;
	end

	logic [1:0] cc_q, cc_want;
	assign cc_want = {seen_q[1] && !gone[1], seen_q[0] && !gone[0]};
	assign any_stop = global_stop || |(cc_q & ~cc_ok) || |(cc_q & hot);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cc_q <= 2'b00;
		else if (any_stop || wake_q != 2'b00)
			cc_q <= 2'b00;
		// Resume only once every present battery is fit again
		else if (cc_q == 2'b00 && tick && (cc_want & ~(cc_ok & ~hot)) == 2'b00)
			cc_q <= cc_want;
	end
	assign charging_any = |cc_q;

	logic signed [17:0] diff0, diff1, step, sum;
	logic [16:0] ilim32, cap, reqmax;
	assign diff0 = 18'(signed'({2'b00, reqi_q[0]})) - 18'(signed'({2'b00, acti_q[0]}));
	assign diff1 = 18'(signed'({2'b00, reqi_q[1]})) - 18'(signed'({2'b00, acti_q[1]}));
	assign step  = (cc_q == 2'b11) ? ((diff0 < diff1) ? diff0 : diff1)
		: (cc_q[1] ? diff1 : diff0);
	assign sum   = signed'({2'b00, prog_current}) + step;
	// cap at larger request of the charging batteries plus limit/32, never above limit
	assign ilim32 = 17'(I_LIMIT >> LIMIT_SHIFT);
	assign reqmax = {1'b0, (cc_q[1] && reqi_q[1] > reqi_q[0]) || !cc_q[0]
		? reqi_q[1] : reqi_q[0]} + ilim32;
	assign cap = (reqmax < {1'b0, I_LIMIT}) ? reqmax : {1'b0, I_LIMIT};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prog_current     <= '0;
			prog_voltage     <= '0;
			low_current_mode <= 1'b0;
			charge_en        <= 2'b00;
		end
		else if (wake_q != 2'b00 && !global_stop)
		begin
			prog_current     <= I_WAKE;
			prog_voltage     <= wake_q[0] ? reqv_q[0] : reqv_q[1];
			low_current_mode <= 1'b1;
			charge_en        <= wake_q;
		end
		else if (any_stop || !charging_any)
		begin
			prog_current     <= '0;
			prog_voltage     <= '0;
			low_current_mode <= 1'b0;
			charge_en        <= 2'b00;
		end
		else
		begin
			low_current_mode <= 1'b0;
			charge_en        <= cc_q;
			prog_voltage     <= (reqv_q[0] < V_LIMIT) ? reqv_q[0] : V_LIMIT;
			if (tick)
			begin
				if (sum < 18'sd0)
					prog_current <= '0;
				else if (17'(sum) > cap)
					prog_current <= 16'(cap);
				else
					prog_current <= 16'(sum);
			end
		end
	end

	// APB: zero wait states, unmapped reads zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= '0;
		else if (psel && !penable)
			unique case (paddr)
				ADDR_CTRL:   prdata <= {28'h0, ctrl_q};
				ADDR_STATUS: prdata <= {20'h0, stuck_q, alarm_q, wake_q, cc_q, ac_ok,
					hw_inhibit, estop, answered_q};
				ADDR_IPROG:  prdata <= {prog_voltage, prog_current};
				default:     prdata <= '0;
			endcase
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
		end
	end

	// Assertions
	a_stop_zeroes_current: assert property (@(posedge pclk) disable iff (!presetn)
		any_stop && wake_q == 2'b00 |=> prog_current == 16'h0000 && charge_en == 2'b00)
		else $error("current not zeroed after stop");
	a_current_capped: assert property (@(posedge pclk) disable iff (!presetn)
		charge_en != 2'b00 && !low_current_mode |-> prog_current <= I_LIMIT)
		else $error("programmed current above limit");
	a_wake_single: assert property (@(posedge pclk) disable iff (!presetn)
		wake_q != 2'b11)
		else $error("two batteries in wake-up");
	a_wake_fixed_current: assert property (@(posedge pclk) disable iff (!presetn)
		wake_q != 2'b00 && !global_stop |=> prog_current == I_WAKE && low_current_mode)
		else $error("wake-up current not fixed");
	a_inhibit_stops: assert property (@(posedge pclk) disable iff (!presetn)
		sw_inhibit |=> ##1 charge_en == 2'b00)
		else $error("charging during inhibit");
	a_png_stops: assert property (@(posedge pclk) disable iff (!presetn)
		pwr_ng || estop |=> ##1 charge_en == 2'b00)
		else $error("charging during power fault");
	a_update_on_tick: assert property (@(posedge pclk) disable iff (!presetn)
		!$past(tick) && !low_current_mode && $past(!low_current_mode)
		&& prog_current != 16'h0000 |-> $stable(prog_current))
		else $error("current changed off tick");
	a_stuck_stops: assert property (@(posedge pclk) disable iff (!presetn)
		stuck_q |=> ##1 charge_en == 2'b00)
		else $error("charging with stuck bus");
endmodule : dbcc_top
`default_nettype wire

// >>> tb/dbcc_battery_model.sv
// Behavioural pair of smart batteries answering the poll engine
`default_nettype none
module dbcc_battery_model
	import dbcc_pkg::*;
(
	input  wire logic      pclk,
	input  wire logic      presetn,
	input  wire dbcc_req_s poll_req,
	output dbcc_rsp_s      poll_rsp
);
	timeunit 1ns;
	timeprecision 1ps;
	// Word per battery and command: alarm, chgv, volt, chgi, curr
	logic [15:0] val [2][5] = '{'{16'h0000, 16'h3A98, 16'h3A00, 16'h03E8, 16'h0384},
		'{16'h0000, 16'h3A98, 16'h3A00, 16'h0320, 16'h02BC}};
	logic [1:0]  ack = 2'h3;
	logic        wr = 1'b0;
	int          lag = 0;
	logic        b;
	dbcc_cmd_e   c;
	logic [15:0] d;
	initial
	begin
		poll_rsp = '0;
		forever
		begin
			@(posedge pclk);
			if (presetn === 1'b1 && poll_req.valid === 1'b1)
			begin
				repeat (lag) @(posedge pclk);
				b = poll_req.bat;
				c = poll_req.cmd;
				d = val[b][c];
				// answer each polled read; silent battery garbles data
				poll_rsp <= '{1'b1, b, ack[b], 1'b0, c, ack[b] ? d : ~d};
				@(posedge pclk);
				if (wr)
				begin
					// stray battery write asking zero current
					poll_rsp <= '{1'b1, b, 1'b1, 1'b1, CMD_CHGI, 16'h0000};
					@(posedge pclk);
				end
				poll_rsp <= '0;
				@(posedge pclk);
			end
		end
	end
endmodule : dbcc_battery_model
`default_nettype wire

// >>> tb/dbcc_top_test.sv
// Self-checking bench for the dual battery charge control block
`default_nettype none
module dbcc_top_test
	import dbcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Short period keeps the run small
	localparam int QC = 96;
	localparam logic [15:0] ILIM = 16'h0FA0;
	localparam logic [15:0] IWAKE = 16'h0050;
	typedef struct packed
	{
		logic [2:0] t1;
		logic [2:0] t2;
		logic [3:0] ctl;
		logic [3:0] env;
		logic [1:0] en;
	} dbcc_row_s;
	// env is {mains, mode, supply, estop}
	dbcc_row_s rows [10] = '{
		'{3'h2, 3'h2, 4'h0, 4'hC, 2'h3}, '{3'h1, 3'h0, 4'h0, 4'hC, 2'h3},
		'{3'h4, 3'h2, 4'h0, 4'hC, 2'h2}, '{3'h2, 3'h2, 4'h1, 4'hC, 2'h0},
		'{3'h2, 3'h2, 4'h0, 4'h4, 2'h0}, '{3'h2, 3'h2, 4'h0, 4'hA, 2'h0},
		'{3'h2, 3'h2, 4'h0, 4'hD, 2'h0}, '{3'h2, 3'h2, 4'h4, 4'hC, 2'h0},
		'{3'h3, 3'h2, 4'h0, 4'hC, 2'h0}, '{3'h2, 3'h2, 4'h0, 4'hC, 2'h3}};
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        mains_present, mode_pin, smbus_supply, mains_sense_divided;
	logic        low_current_mode;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0]  therm1, therm2;
	logic [3:0]  smb_lines;
	logic [15:0] prog_current, prog_voltage;
	logic [1:0]  charge_en;
	dbcc_req_s   poll_req;
	dbcc_rsp_s   poll_rsp;
	int          mismatches = 0;
	int          compares = 0;
	int          cyc = 0;
	dbcc_top #(.QUERY_CYC(QC), .TMO_QRY(3), .I_LIMIT(ILIM), .I_WAKE(IWAKE)) uut (
		.pclk                (pclk),
		.presetn             (presetn),
		.psel                (psel),
		.penable             (penable),
		.pwrite              (pwrite),
		.paddr               (paddr),
		.pwdata              (pwdata),
		.pready              (pready),
		.prdata              (prdata),
		.pslverr             (pslverr),
		.therm1              (therm1),
		.therm2              (therm2),
		.mains_present       (mains_present),
		.mode_pin            (mode_pin),
		.smbus_supply        (smbus_supply),
		.mains_sense_divided (mains_sense_divided),
		.smb_lines           (smb_lines),
		.poll_req            (poll_req),
		.poll_rsp            (poll_rsp),
		.prog_current        (prog_current),
		.prog_voltage        (prog_voltage),
		.low_current_mode    (low_current_mode),
		.charge_en           (charge_en)
	);
	dbcc_battery_model bat (.pclk(pclk), .presetn(presetn), .poll_req(poll_req),
		.poll_rsp(poll_rsp));
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic complete_run;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	// Cut a hang short
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			mismatches++;
			complete_run();
		end
	end
	task automatic chk_port(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD port t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_port
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD reg t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_reg
	// Entered right after a rising edge; waits for pready at most 50 edges
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so a following call never rewrites psel in this step
		@(posedge pclk);
		if (n == 50 && rd !== prdata)
			n = 50;
		if (n >= 50)
		begin
			mismatches++;
			complete_run();
		end
	endtask : apb
	task automatic ticks(input int n);
		repeat (n * QC) @(posedge pclk);
	endtask : ticks
	function automatic logic [31:0] exp_cur(input logic [1:0] en);
		logic [15:0] q1, q2, m;
		q1 = bat.val[0][3];
		q2 = bat.val[1][3];
		m = (en == 2'h1) ? q1 : (en == 2'h2) ? q2 : (q1 > q2) ? q1 : q2;
		m = m + (ILIM >> 5);
		if (m > ILIM)
			m = ILIM;
		return (en == 2'h0) ? 32'h0 : {16'h0, m};
	endfunction : exp_cur
	initial
	begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{therm1, therm2, smb_lines} = {3'h2, 3'h2, 4'hF};
		{mains_present, mode_pin, smbus_supply, mains_sense_divided} = 4'hC;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk_port(32'(charge_en), 32'h0);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk_reg(rd, 32'h0);
		apb(1'b0, 8'h0C, 32'h0);
		chk_reg(rd, 32'h0);
		bat.lag <= 2;
		foreach (rows[i])
		begin
			{therm1, therm2} <= {rows[i].t1, rows[i].t2};
			{mains_present, mode_pin, smbus_supply, mains_sense_divided} <= rows[i].env;
			apb(1'b1, ADDR_CTRL, 32'(rows[i].ctl));
			ticks(30);
			chk_port(32'(charge_en), 32'(rows[i].en));
			chk_port(32'(prog_current), exp_cur(rows[i].en));
		end
		bat.lag <= 0;
		bat.wr <= 1'b1;
		ticks(5);
		chk_port(32'(charge_en), 32'h3);
		bat.wr <= 1'b0;
		for (int k = 11; k < 16; k++)
		begin
			bat.val[0][0] <= 16'h0001 << k;
			ticks(3);
			chk_port(32'(charge_en), (k == 11) ? 32'h3 : 32'h0);
			bat.val[0][0] <= 16'h0000;
			ticks(20);
			chk_port(32'(charge_en), 32'h3);
		end
		bat.val[0][0] <= 16'h8000;
		ticks(3);
		chk_port(32'(prog_current), 32'h0);
		bat.ack[0] <= 1'b0;
		bat.val[0][0] <= 16'h0000;
		ticks(2);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk_reg(32'(rd[10:9]), 32'h1);
		apb(1'b1, ADDR_CTRL, 32'(1 << CTL_POR));
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk_reg(32'(rd[10:9]), 32'h0);
		bat.ack[0] <= 1'b1;
		ticks(30);
		chk_port(32'(charge_en), 32'h3);
		bat.val[1][3] <= 16'h0000;
		ticks(3);
		chk_port(32'(charge_en), 32'h0);
		bat.val[1][3] <= 16'h0320;
		bat.ack[1] <= 1'b0;
		ticks(30);
		chk_port(32'(charge_en), 32'h0);
		bat.ack[1] <= 1'b1;
		ticks(30);
		smb_lines <= 4'hE;
		ticks(3);
		chk_port(32'(charge_en), 32'h0);
		smb_lines <= 4'hF;
		bat.ack <= 2'h0;
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		ticks(4);
		chk_port(32'(charge_en), 32'h1);
		chk_port(32'({low_current_mode, prog_current}), {15'h0, 1'b1, IWAKE});
		bat.ack[0] <= 1'b1;
		ticks(4);
		chk_port(32'(charge_en), 32'h2);
		apb(1'b1, ADDR_CTRL, 32'(1 << CTL_CALIB));
		ticks(1);
		chk_port(32'(charge_en), 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h0);
		bat.ack[1] <= 1'b1;
		ticks(30);
		chk_port(32'({low_current_mode, charge_en}), 32'h3);
		complete_run();
	end
endmodule : dbcc_top_test
`default_nettype wire
